// ### hw/nvm_lock_defs.vh
`ifndef NVM_LOCK_DEFS_VH
`define NVM_LOCK_DEFS_VH

// Register offsets on the plain register port
`define LOCK_ADDR_LEVELS     4'h0
`define LOCK_ADDR_STATUS     4'h1
`define LOCK_ADDR_EXT_PEND   4'h2

// Field positions in the protection level byte
`define LOCK_BOOT_HI         7
`define LOCK_BOOT_LO         6
`define LOCK_APP_HI          5
`define LOCK_APP_LO          4
`define LOCK_TBL_HI          3
`define LOCK_TBL_LO          2
`define LOCK_EXT_HI          1
`define LOCK_EXT_LO          0

// Reset value of the protection level byte (erased state)
`define LOCK_LEVELS_RESET    8'hFF

// Two-bit level encodings
`define LVL_UNPROTECTED      2'h3
`define LVL_WRITE_PROTECTED  2'h2
`define LVL_READ_PROTECTED   2'h1
`define LVL_READ_WRITE       2'h0

// Section codes for the current program counter region
`define SECT_APP             2'h0
`define SECT_TABLE           2'h1
`define SECT_BOOT            2'h2

// Chip erase duration in clock cycles
`define ERASE_CYCLES         4'h8

`endif

// ### hw/lock_section_check.v
`timescale 1ns/1ns
`include "nvm_lock_defs.vh"

// Decides whether one CPU access to program memory is permitted
module lock_section_check
(
    input  wire [1:0] level_i,
    input  wire [1:0] exec_sect_i,
    input  wire       target_boot_i,
    input  wire       is_write_i,
    output wire       allow_o
);

    wire read_locked;
    wire write_locked;
    wire cross_read;

    // Bit 0 low blocks self-program writes, bit 1 low blocks cross-section reads
    assign write_locked = ~level_i[0];
    assign read_locked  = ~level_i[1];
    assign cross_read   = target_boot_i ? (exec_sect_i != `SECT_BOOT) : (exec_sect_i == `SECT_BOOT);
    assign allow_o      = is_write_i ? ~write_locked : ~(read_locked & cross_read);

endmodule

// ### hw/nvm_lock_level_guard.v
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ns
`include "nvm_lock_defs.vh"

// Behaviour
// - Boot field writes only tighten; relaxing writes leave it unchanged (code ANDs per bit: a write raising one bit still applies a lowered one).
// - Boot field returns to unprotected only by chip erase.
// - Boot field: 11 open, 10 no writes, 01 no app reads, 00 both.
// - Boot read-locked with vectors in app: interrupts off in boot code.
// - Application field only moves to stricter locking.
// - Application field cleared only by chip erase.
// - Application field: 11 open, 10 no writes, 01 no boot reads, 00 both.
// - App or table read-locked, vectors in boot: interrupts off in app code.
// - Table field only written to a stricter setting.
// - Table field restored to unrestricted only by chip erase.
// - Table field: 11 open, 10 no writes, 01 no boot reads, 00 both.
// - External field sets flash/EEPROM protection for outside programming.
// - External field written only from the external programming port.
// - External field cleared only during chip erase.
// - Any external bit zero blocks test interface and debugger memory access.
// - External field never restricts processor software accesses.
// - External field 11: no locks on the programming interface.
// - External field 10: refuse flash, EEPROM and fuse writes.
// - External field 00: refuse memory program, read-back, fuse and lock access.
module nvm_lock_level_guard
(
    input  wire        clk_i,
    input  wire        rst_b_i,
    // Register port
    input  wire [3:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    // CPU program memory access check
    input  wire        cpu_req_i,
    input  wire        cpu_write_i,
    input  wire [1:0]  cpu_target_sect_i,
    input  wire [1:0]  cpu_exec_sect_i,
    input  wire        vectors_in_boot_i,
    output wire        cpu_allow_o,
    output wire        irq_block_o,
    // External programming interface
    input  wire        ext_lock_wr_i,
    input  wire [7:0]  ext_lock_wdata_i,
    input  wire        ext_req_i,
    input  wire [2:0]  ext_kind_i,
    output wire        ext_allow_o,
    input  wire        chip_erase_i,
    output wire        erase_busy_o,
    // Debug paths
    input  wire        dbg_req_i,
    output wire        dbg_allow_o,
    output wire [7:0]  levels_o
);

    // External access kinds
    localparam [2:0] KIND_MEM_WRITE  = 3'h0;
    localparam [2:0] KIND_MEM_READ   = 3'h1;
    localparam [2:0] KIND_FUSE_WRITE = 3'h2;
    localparam [2:0] KIND_FUSE_READ  = 3'h3;
    localparam [2:0] KIND_LOCK_READ  = 3'h4;
    localparam [2:0] KIND_LOCK_WRITE = 3'h5;

    // Erase state machine
    localparam [0:0] ST_IDLE  = 1'b0;
    localparam [0:0] ST_ERASE = 1'b1;

    // Protection byte and erase sequencer state
    reg  [7:0] levels_q;
    reg  [7:0] levels_d;
    reg  [0:0] state_q;
    reg  [0:0] state_d;
    reg  [3:0] erase_cnt_q;
    reg  [3:0] erase_cnt_d;

    // Chip erase request synchroniser and edge detector
    reg        erase_s1_q;
    reg        erase_s2_q;
    reg        erase_s3_q;
    reg        erase_lvl_q;
    reg        erase_prev_q;

    // Sticky status bits and the external permission result
    reg        rejected_q;
    reg        rejected_d;
    reg        ext_written_q;
    reg        ext_written_d;
    reg        ext_allow_r;

    // Field views of the stored byte
    wire [1:0] boot_lvl;
    wire [1:0] app_lvl;
    wire [1:0] tbl_lvl;
    wire [1:0] ext_lvl;

    // Decoded strobes and section permission
    wire [1:0] target_lvl;
    wire       sect_allow;
    wire       erase_start;
    wire       erase_done;
    wire       sw_wr_levels;
    wire       status_rd;
    wire       ext_wr_ok;
    wire [7:0] sw_data;

    // Per-field relax flags, read-lock flags and external request class
    wire [3:0] sw_relax_fld;
    wire       sw_relaxes;
    wire [3:1] fld_rd_lock;
    wire [2:0] ext_class;
    genvar     gi;

    // Returns one when any bit of a new value tries to rise above the old
    function relaxes;
        input [7:0] old_v;
        input [7:0] new_v;
        begin
            relaxes = |(new_v & ~old_v);
        end
    endfunction

    // Picks the level field of the section that is targeted
    function [1:0] sect_level;
        input [1:0] sect;
        input [7:0] lv;
        begin
            case (sect)
                `SECT_BOOT:  sect_level = lv[`LOCK_BOOT_HI:`LOCK_BOOT_LO];
                `SECT_TABLE: sect_level = lv[`LOCK_TBL_HI:`LOCK_TBL_LO];
                default:     sect_level = lv[`LOCK_APP_HI:`LOCK_APP_LO];
            endcase
        end
    endfunction

    // Sorts an external request: program writes, memory read-back, fuse or lock access
    function [2:0] kind_class;
        input [2:0] kind;
        begin
            kind_class[0] = (kind == KIND_MEM_WRITE) || (kind == KIND_FUSE_WRITE);
            kind_class[1] = (kind == KIND_MEM_READ);
            kind_class[2] = (kind == KIND_FUSE_READ) || (kind == KIND_LOCK_READ) || (kind == KIND_LOCK_WRITE);
        end
    endfunction

    // Field views and the register copy
    assign boot_lvl = levels_q[`LOCK_BOOT_HI:`LOCK_BOOT_LO];
    assign app_lvl  = levels_q[`LOCK_APP_HI:`LOCK_APP_LO];
    assign tbl_lvl  = levels_q[`LOCK_TBL_HI:`LOCK_TBL_LO];
    assign ext_lvl  = levels_q[`LOCK_EXT_HI:`LOCK_EXT_LO];
    assign levels_o = levels_q;

    // Chip erase request arrives from the programming clock side: three stages
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            erase_s1_q   <= 1'b0;
            erase_s2_q   <= 1'b0;
            erase_s3_q   <= 1'b0;
            erase_lvl_q  <= 1'b0;
            erase_prev_q <= 1'b0;
        end
        else
        begin
            erase_s1_q   <= chip_erase_i;
            erase_s2_q   <= erase_s1_q;
            erase_s3_q   <= erase_s2_q;
            if (erase_s2_q == erase_s3_q)
                erase_lvl_q <= erase_s3_q;
            erase_prev_q <= erase_lvl_q;
        end
    end

    // One-cycle pulse on the filtered rising edge
    assign erase_start = erase_lvl_q & ~erase_prev_q;

    // Software only touches the three section fields; external bits are masked
    assign sw_wr_levels = reg_wr_i && (reg_addr_i == `LOCK_ADDR_LEVELS);
    assign sw_data      = {reg_wdata_i[7:2], 2'h3};

    // Status clear strobe, and external writes only while the external field is open
    assign status_rd = reg_rd_i && (reg_addr_i == `LOCK_ADDR_STATUS);
    assign ext_wr_ok = ext_lock_wr_i && (ext_lvl == `LVL_UNPROTECTED);

    // Relax detection per section field; the forced external bits never count
    generate
        for (gi = 1; gi < 4; gi = gi + 1)
        begin : g_sw_relax
            assign sw_relax_fld[gi] = |(reg_wdata_i[2*gi+1:2*gi] & ~levels_q[2*gi+1:2*gi]);
        end
    endgenerate
    assign sw_relax_fld[0] = 1'b0;
    assign sw_relaxes      = |sw_relax_fld;

    // Read-lock decode per section field: bit 1 low locks foreign reads
    generate
        for (gi = 1; gi < 4; gi = gi + 1)
        begin : g_rd_lock
            assign fld_rd_lock[gi] = ~levels_q[2*gi+1];
        end
    endgenerate

    // Level update: tighten-only writes, chip erase restores the levels and ext_written_q but not rejected_q
    always @*
    begin
        levels_d      = levels_q;
        state_d       = state_q;
        erase_cnt_d   = erase_cnt_q;
        rejected_d    = rejected_q;
        ext_written_d = ext_written_q;
        // Status read clears first so that a relax in the same cycle still sets
        if (status_rd)
            rejected_d = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (erase_start)
                begin
                    state_d     = ST_ERASE;
                    erase_cnt_d = `ERASE_CYCLES;
                end
                else
                begin
                    if (sw_wr_levels)
                    begin
                        levels_d = levels_d & sw_data;
                        if (sw_relaxes)
                            rejected_d = 1'b1;
                    end
                    if (ext_wr_ok)
                    begin
                        levels_d = levels_d & ext_lock_wdata_i;
                        if (relaxes(levels_q, ext_lock_wdata_i))
                            rejected_d = 1'b1;
                        if (ext_lock_wdata_i[1:0] != `LVL_UNPROTECTED)
                            ext_written_d = 1'b1;
                    end
                end
            end
            ST_ERASE:
            begin
                erase_cnt_d = erase_cnt_q - 4'h1;
                if (erase_done)
                begin
                    levels_d      = `LOCK_LEVELS_RESET;
                    ext_written_d = 1'b0;
                    state_d       = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State registers
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            levels_q      <= `LOCK_LEVELS_RESET;
            state_q       <= ST_IDLE;
            erase_cnt_q   <= 4'h0;
            rejected_q    <= 1'b0;
            ext_written_q <= 1'b0;
        end
        else
        begin
            levels_q      <= levels_d;
            state_q       <= state_d;
            erase_cnt_q   <= erase_cnt_d;
            rejected_q    <= rejected_d;
            ext_written_q <= ext_written_d;
        end
    end

    // Busy for the whole erase countdown; done marks its last cycle
    assign erase_busy_o = (state_q == ST_ERASE);
    assign erase_done   = (state_q == ST_ERASE) && (erase_cnt_q == 4'h1);

    // CPU access decode per section level; external field plays no part
    assign target_lvl = sect_level(cpu_target_sect_i, levels_q);

    lock_section_check u_check
    (
        .level_i       (target_lvl),
        .exec_sect_i   (cpu_exec_sect_i),
        .target_boot_i (cpu_target_sect_i == `SECT_BOOT),
        .is_write_i    (cpu_write_i),
        .allow_o       (sect_allow)
    );

    // Section permission, held off during erase
    assign cpu_allow_o = cpu_req_i & sect_allow & ~erase_busy_o;

    // Interrupt suppression when the executing side (boot, or app and table) is read-locked and vectors sit on the other side
    assign irq_block_o = (fld_rd_lock[3] & ~vectors_in_boot_i & (cpu_exec_sect_i == `SECT_BOOT))
                       | ((fld_rd_lock[2] | fld_rd_lock[1]) & vectors_in_boot_i
                          & (cpu_exec_sect_i != `SECT_BOOT));

    // Request class of the external access
    assign ext_class = kind_class(ext_kind_i);

    // External programming permission by external level
    always @*
    begin
        ext_allow_r = 1'b0;
        case (ext_lvl)
            `LVL_UNPROTECTED:
                ext_allow_r = 1'b1;
            `LVL_WRITE_PROTECTED:
                ext_allow_r = ~ext_class[0];
            default:
                ext_allow_r = ~|ext_class;
        endcase
    end

    // Outward permissions, all held off during erase
    assign ext_allow_o = ext_req_i & ext_allow_r & ~erase_busy_o;
    assign dbg_allow_o = dbg_req_i & (&ext_lvl) & ~erase_busy_o;

    // Register read port, data one cycle after the strobe
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `LOCK_ADDR_LEVELS:   reg_rdata_o <= levels_q;
                `LOCK_ADDR_STATUS:   reg_rdata_o <= {6'h00, rejected_q, erase_busy_o};
                `LOCK_ADDR_EXT_PEND: reg_rdata_o <= {7'h00, ext_written_q};
                default:             reg_rdata_o <= 8'h00;
            endcase
        end
        else
            reg_rdata_o <= 8'h00;
    end

endmodule

// ### bench/nvm_lock_level_guard_assertions.sv
`timescale 1ns/1ns
// Watches the lock guard ports for level and permission slips
module nvm_lock_checker (
    input wire       clk_i,
    input wire       rst_b_i,
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       reg_wr_i,
    input wire       ext_lock_wr_i,
    input wire       cpu_req_i,
    input wire       cpu_write_i,
    input wire [1:0] cpu_target_sect_i,
    input wire [1:0] cpu_exec_sect_i,
    input wire       vectors_in_boot_i,
    input wire       cpu_allow_o,
    input wire       irq_block_o,
    input wire [2:0] ext_kind_i,
    input wire       ext_allow_o,
    input wire       erase_busy_o,
    input wire       dbg_req_i,
    input wire       dbg_allow_o,
    input wire [7:0] levels_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Permission outputs and level updates against the stored levels
    property p_dbg; dbg_allow_o |-> dbg_req_i && levels_o[1:0] == 2'h3 && !erase_busy_o; endproperty
    a_dbg: assert property (p_dbg) else $error("debug access allowed while locked");
    property p_fall; |(levels_o & ~$past(levels_o)) |-> $past(erase_busy_o) || $past(erase_busy_o, 2); endproperty
    a_fall: assert property (p_fall) else $error("level bit rose without erase");
    property p_and; reg_wr_i && reg_addr_i == 4'h0 && !ext_lock_wr_i && !erase_busy_o |=>
        levels_o == ($past(levels_o) & {$past(reg_wdata_i[7:2]), 2'h3}); endproperty
    a_and: assert property (p_and) else $error("software write not merged");
    property p_boot_wr; cpu_allow_o && cpu_write_i && cpu_target_sect_i == 2'h2 |-> levels_o[6]; endproperty
    a_boot_wr: assert property (p_boot_wr) else $error("boot write allowed");
    property p_app_rd; cpu_allow_o && !cpu_write_i && cpu_target_sect_i == 2'h0 && cpu_exec_sect_i == 2'h2
        |-> levels_o[5]; endproperty
    a_app_rd: assert property (p_app_rd) else $error("app read from boot allowed");
    property p_ext_wr; ext_allow_o && (ext_kind_i == 3'h0 || ext_kind_i == 3'h2) |-> levels_o[0]; endproperty
    a_ext_wr: assert property (p_ext_wr) else $error("external write allowed");
    property p_ext_rd; ext_allow_o && ext_kind_i < 3'h6 |-> levels_o[1]; endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("external access allowed");
    property p_irq_boot; cpu_exec_sect_i == 2'h2 && !vectors_in_boot_i && !levels_o[7] |-> irq_block_o; endproperty
    a_irq_boot: assert property (p_irq_boot) else $error("interrupts left on in boot");
    property p_irq_app; cpu_exec_sect_i == 2'h0 && vectors_in_boot_i && !(levels_o[5] && levels_o[3])
        |-> irq_block_o; endproperty
    a_irq_app: assert property (p_irq_app) else $error("interrupts left on in app");
    property p_sw_open; cpu_req_i && levels_o[7:2] == 6'h3F && !erase_busy_o |-> cpu_allow_o; endproperty
    a_sw_open: assert property (p_sw_open) else $error("software access refused");
    // Main scenarios reached
    c_erase: cover property ($rose(erase_busy_o));
    c_dbg_off: cover property (dbg_req_i && !dbg_allow_o);
    c_irq: cover property (irq_block_o);
endmodule

// ### bench/lock_programmer_model.sv
`timescale 1ns/1ns
// External programmer: section fields first, external field last
module lock_programmer_model (
    input  wire       clk_i,
    output reg        ext_lock_wr_o,
    output reg  [7:0] ext_lock_wdata_o,
    output reg        ext_req_o,
    output reg  [2:0] ext_kind_o
);
    // Idle lines at time zero
    initial
    begin
        ext_lock_wr_o = 1'b0;
        ext_lock_wdata_o = 8'h00;
        ext_req_o = 1'b0;
        ext_kind_o = 3'h0;
    end
    // Two back-to-back writes; released data shows the inverse
    task program_byte(input [7:0] v);
        begin
            @(posedge clk_i);
            ext_lock_wr_o <= 1'b1;
            ext_lock_wdata_o <= {v[7:2], 2'h3};
            @(posedge clk_i);
            ext_lock_wdata_o <= v;
            @(posedge clk_i);
            ext_lock_wr_o <= 1'b0;
            ext_lock_wdata_o <= ~v;
        end
    endtask
    // Holds one access request of the given kind
    task request(input [2:0] k);
        begin
            @(posedge clk_i);
            ext_req_o <= 1'b1;
            ext_kind_o <= k;
        end
    endtask
endmodule

// ### bench/test_nvm_lock_level_guard.sv
`timescale 1ns/1ns
module test_nvm_lock_level_guard;
    reg        clk_i, rst_b_i, reg_wr_i, reg_rd_i, cpu_req_i, cpu_write_i;
    reg        vectors_in_boot_i, chip_erase_i, dbg_req_i, wb, vb;
    reg  [3:0] reg_addr_i;
    reg  [7:0] reg_wdata_i, exp_lv, sb;
    reg  [1:0] cpu_target_sect_i, cpu_exec_sect_i, tg, ex;
    reg [31:0] seed;
    wire [7:0] reg_rdata_o, ext_lock_wdata_i, levels_o;
    wire [2:0] ext_kind_i;
    wire       cpu_allow_o, irq_block_o, ext_lock_wr_i, ext_req_i, ext_allow_o, erase_busy_o, dbg_allow_o;
    integer    n_fail, comparisons, cycles, i, t, x, v, k;
    nvm_lock_level_guard i_dut (
        .clk_i             (clk_i),
        .rst_b_i           (rst_b_i),
        .reg_addr_i        (reg_addr_i),
        .reg_wdata_i       (reg_wdata_i),
        .reg_wr_i          (reg_wr_i),
        .reg_rd_i          (reg_rd_i),
        .reg_rdata_o       (reg_rdata_o),
        .cpu_req_i         (cpu_req_i),
        .cpu_write_i       (cpu_write_i),
        .cpu_target_sect_i (cpu_target_sect_i),
        .cpu_exec_sect_i   (cpu_exec_sect_i),
        .vectors_in_boot_i (vectors_in_boot_i),
        .cpu_allow_o       (cpu_allow_o),
        .irq_block_o       (irq_block_o),
        .ext_lock_wr_i     (ext_lock_wr_i),
        .ext_lock_wdata_i  (ext_lock_wdata_i),
        .ext_req_i         (ext_req_i),
        .ext_kind_i        (ext_kind_i),
        .ext_allow_o       (ext_allow_o),
        .chip_erase_i      (chip_erase_i),
        .erase_busy_o      (erase_busy_o),
        .dbg_req_i         (dbg_req_i),
        .dbg_allow_o       (dbg_allow_o),
        .levels_o          (levels_o)
    );
    lock_programmer_model i_prog (
        .clk_i            (clk_i),
        .ext_lock_wr_o    (ext_lock_wr_i),
        .ext_lock_wdata_o (ext_lock_wdata_i),
        .ext_req_o        (ext_req_i),
        .ext_kind_o       (ext_kind_i)
    );
    // Clock at 125 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Random source
    function [31:0] xs(input [31:0] s);
        reg [31:0] r;
        begin
            r = s ^ (s << 13);
            r = r ^ (r >> 17);
            xs = r ^ (r << 5);
        end
    endfunction
    // CPU permission from field levels and section codes
    function exp_cpu(input [7:0] lv, input [1:0] g, input [1:0] e, input w);
        reg [1:0] f;
        begin
            f = (g == 2'h2) ? lv[7:6] : (g == 2'h1) ? lv[3:2] : lv[5:4];
            exp_cpu = w ? f[0] : (f[1] | ((g == 2'h2) == (e == 2'h2)));
        end
    endfunction
    // Compare and count
    task check(input [7:0] seen, input [7:0] want);
        begin
            comparisons = comparisons + 1;
            if (seen !== want)
            begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
            end
        end
    endtask
    // Register port cycles
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            reg_wr_i <= 1'b1;
            reg_addr_i <= a;
            reg_wdata_i <= d;
            @(posedge clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] want);
        begin
            @(posedge clk_i);
            reg_rd_i <= 1'b1;
            reg_addr_i <= a;
            @(posedge clk_i);
            reg_rd_i <= 1'b0;
            @(negedge clk_i);
            check(reg_rdata_o, want);
        end
    endtask
    // Chip erase with bounded waits
    task erase;
        begin
            @(posedge clk_i);
            chip_erase_i <= 1'b1;
            for (t = 0; t < 20 && erase_busy_o !== 1'b1; t = t + 1)
                @(posedge clk_i);
            check({7'h0, erase_busy_o}, 8'h01);
            chip_erase_i <= 1'b0;
            for (t = 0; t < 20 && erase_busy_o !== 1'b0; t = t + 1)
                @(posedge clk_i);
            exp_lv = 8'hFF;
            rd(4'h0, exp_lv);
        end
    endtask
    // Closing report
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Cycle ceiling
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            n_fail = n_fail + 1;
            print_verdict;
        end
    end
    // Main sequence
    initial
    begin
        {rst_b_i, reg_wr_i, reg_rd_i, cpu_req_i, cpu_write_i, vectors_in_boot_i, chip_erase_i, dbg_req_i} = 8'h00;
        {reg_addr_i, reg_wdata_i, cpu_target_sect_i, cpu_exec_sect_i} = 16'h0000;
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        seed = 32'h0733;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(4'h0, 8'hFF);
        rd(4'h1, 8'h00);
        rd(4'hF, 8'h00);
        $display("test reset done");
        for (i = 0; i < 9; i = i + 1)
        begin
            seed = xs(seed);
            v = (i % 3 == 0) ? 3 : (i % 3 == 1) ? 2 : 0;
            sb = (i == 2) ? 8'hFF : seed[7:0];
            erase;
            i_prog.program_byte({sb[7:2], 2'(v)});
            exp_lv = {sb[7:2], 2'(v)};
            rd(4'h0, exp_lv);
            @(posedge clk_i);
            dbg_req_i <= seed[9];
            @(negedge clk_i);
            check({7'h0, dbg_allow_o}, {7'h0, seed[9] && v == 3});
            for (k = 0; k < 6; k = k + 1)
            begin
                i_prog.request(3'(k));
                @(negedge clk_i);
                check({7'h0, ext_allow_o}, {7'h0, v == 3 || (v == 2 && k != 0 && k != 2)});
            end
            for (x = 0; x < 24; x = x + 1)
            begin
                tg = 2'(x % 3);
                ex = ((x / 3) % 2) ? 2'h2 : 2'h0;
                wb = 1'((x / 6) % 2);
                vb = 1'(x / 12);
                @(posedge clk_i);
                cpu_req_i <= 1'b1;
                cpu_target_sect_i <= tg;
                cpu_exec_sect_i <= ex;
                cpu_write_i <= wb;
                vectors_in_boot_i <= vb;
                @(negedge clk_i);
                check({7'h0, cpu_allow_o}, {7'h0, exp_cpu(exp_lv, tg, ex, wb)});
                check({7'h0, irq_block_o}, {7'h0, (ex == 2'h2 && !vb && !exp_lv[7]) ||
                    (ex == 2'h0 && vb && !(exp_lv[5] && exp_lv[3]))});
            end
            wr(4'h0, seed[23:16]);
            exp_lv = exp_lv & {seed[23:18], 2'h3};
            wr(4'h0, 8'hFF);
            rd(4'h1, {6'h00, exp_lv[7:2] != 6'h3F, 1'b0});
            rd(4'h0, exp_lv);
            $display("test %0d done", i);
        end
        print_verdict;
    end
endmodule
bind nvm_lock_level_guard nvm_lock_checker i_chk (
    .clk_i             (clk_i),
    .rst_b_i           (rst_b_i),
    .reg_addr_i        (reg_addr_i),
    .reg_wdata_i       (reg_wdata_i),
    .reg_wr_i          (reg_wr_i),
    .ext_lock_wr_i     (ext_lock_wr_i),
    .cpu_req_i         (cpu_req_i),
    .cpu_write_i       (cpu_write_i),
    .cpu_target_sect_i (cpu_target_sect_i),
    .cpu_exec_sect_i   (cpu_exec_sect_i),
    .vectors_in_boot_i (vectors_in_boot_i),
    .cpu_allow_o       (cpu_allow_o),
    .irq_block_o       (irq_block_o),
    .ext_kind_i        (ext_kind_i),
    .ext_allow_o       (ext_allow_o),
    .erase_busy_o      (erase_busy_o),
    .dbg_req_i         (dbg_req_i),
    .dbg_allow_o       (dbg_allow_o),
    .levels_o          (levels_o)
);
